// *** core/dbg_trace_pkg.sv ***
// Purpose: Shared constants and carriers for the debug trace block
// Assumes: Byte-wide register port, single bus clock
// Notes:   Register indices select one byte register each
package dbg_trace_pkg;

  // Register indices on the CPU byte port (force-reset is host space)
  localparam logic [3:0] IDX_FORCE_RST = 4'h0;
  localparam logic [3:0] IDX_CMP_A_HI  = 4'h1;
  localparam logic [3:0] IDX_CMP_A_LO  = 4'h2;
  localparam logic [3:0] IDX_CMP_B_HI  = 4'h3;
  localparam logic [3:0] IDX_CMP_B_LO  = 4'h4;
  localparam logic [3:0] IDX_FIFO_HI   = 4'h5;
  localparam logic [3:0] IDX_FIFO_LO   = 4'h6;
  localparam logic [3:0] IDX_CTRL      = 4'h7;
  localparam logic [3:0] IDX_TRIG      = 4'h8;
  localparam logic [3:0] IDX_STATUS    = 4'h9;

  // Field positions in debug_ctrl
  localparam int BIT_ENABLE   = 7;
  localparam int BIT_ARM      = 6;
  localparam int BIT_TAG      = 5;
  localparam int BIT_BRK_EN   = 4;
  localparam int BIT_A_TYPE   = 3;
  localparam int BIT_A_QUAL   = 2;
  localparam int BIT_B_TYPE   = 1;
  localparam int BIT_B_QUAL   = 0;
  // Field positions in the force-reset and status bytes
  localparam int BIT_FORCE_RST = 0;
  localparam int BIT_ARMED_ST  = 5;

  // Reset values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [3:0]  RST_COUNT  = 4'h0;

  // Trace FIFO geometry
  localparam int          FIFO_DEPTH = 8;
  localparam int          FIFO_WIDTH = 16;
  localparam logic [3:0]  FIFO_FULL  = 4'h8;

  // Monitored CPU bus cycle
  typedef struct packed {
    logic        valid;   // Bus cycle present this clock
    logic        read;    // 1 read, 0 write
    logic        fetch;   // Opcode fetch cycle
    logic        cof;     // Change-of-flow address worth tracing
    logic [15:0] addr;
    logic [7:0]  data;
  } mon_s;

  // CPU register access
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] idx;
    logic [7:0] wdata;
  } reg_req_s;

endpackage : dbg_trace_pkg

// *** core/debug_trace_and_force_reset.sv ***
// Purpose: Debug comparators, trace FIFO, control and force-reset regs
// Assumes: CPU and host requests are one-cycle strobes on clock_i
// Notes:   Trigger mode and begin/end choice arrive as plain inputs

// Functional notes
// - CPU writes to force_reset_ctrl are ignored; only host writes act
// - force_reset_ctrl always reads 0x00
// - Host writing one to bit 0 requests a full system reset
// - Comparator bytes reset to 0x00, always readable, write-locked when armed
// - Three split 16-bit registers plus three 8-bit control/status bytes
// - Nine debug bytes sit in the ordinary register map
// - FIFO high byte is read-only, reads zero in event-only modes
// - Reading FIFO high byte never advances the FIFO
// - Reading FIFO low byte advances the FIFO; writes do nothing
// - Event-only entries hold a data byte in the low half only
// - While armed, low-byte reads do not advance the FIFO
// - Unarmed low-byte read loads last fetched opcode address at FIFO end
// - Ninth profiling read returns address captured by the first read
// - Bit 7 enables the module; cannot be set while secured
// - Bit 6 arms capture, sets armed flag, clears at run end
// - Bit 5 picks force or tag break type, only with breaks enabled
// - Bit 4 lets triggers raise a break; captures continue without it
// - End trace breaks on trigger, begin trace breaks on FIFO full
// - Bit 2 qualifies comparator A by access; bit 3 picks read or write
// - Bit 0 qualifies comparator B by access; bit 1 picks read or write
// - Run ends on full in begin trace, trigger in end trace, or software
module debug_trace_and_force_reset (
  // Clock and reset
  input  wire logic                    clock_i,
  input  wire logic                    rst_i,
  // CPU register port
  input  wire dbg_trace_pkg::reg_req_s cpu_req_i,
  output logic [7:0]                   rdata_o,
  // Serial debug host memory-write port
  input  wire logic                    host_wr_i,
  input  wire logic [3:0]              host_idx_i,
  input  wire logic [7:0]              host_wdata_i,
  // Chip state and trigger setup
  input  wire logic                    secure_i,
  input  wire logic                    event_only_i,
  input  wire logic                    begin_trace_i,
  // Monitored CPU bus
  input  wire dbg_trace_pkg::mon_s     mon_i,
  // Results
  output logic                         sys_reset_o,
  output logic                         break_req_o,
  output logic                         break_tag_o,
  output logic                         armed_o
);

  logic [7:0]  cmp_a_hi_ff;
  logic [7:0]  cmp_a_lo_ff;
  logic [7:0]  cmp_b_hi_ff;
  logic [7:0]  cmp_b_lo_ff;
  logic [7:0]  ctrl_ff;
  logic [3:0]  count_ff;
  logic        started_ff;
  logic [15:0] op_addr_ff;
  logic [15:0] fifo_ff [dbg_trace_pkg::FIFO_DEPTH];
  logic [7:0]  rdata_ff;
  logic        sys_reset_ff;
  logic        break_req_ff;
  logic        break_tag_ff;

  logic        enable;
  logic        armed;
  logic        cpu_wr_ctrl;
  logic        rd_lo;
  logic        match_a;
  logic        match_b;
  logic        trigger;
  logic        begin_mode;
  logic        store;
  logic [15:0] store_word;
  logic        run_full;
  logic        run_done;
  logic        brk_fire;
  logic [7:0]  nxt_rdata;

  assign enable      = ctrl_ff[dbg_trace_pkg::BIT_ENABLE];
  assign armed       = ctrl_ff[dbg_trace_pkg::BIT_ARM];
  assign cpu_wr_ctrl = cpu_req_i.wr &&
                       cpu_req_i.idx == dbg_trace_pkg::IDX_CTRL;
  assign rd_lo       = cpu_req_i.rd &&
                       cpu_req_i.idx == dbg_trace_pkg::IDX_FIFO_LO;

  // Comparators with optional read/write qualification
  assign match_a = mon_i.valid &&
                   mon_i.addr == {cmp_a_hi_ff, cmp_a_lo_ff} &&
                   (!ctrl_ff[dbg_trace_pkg::BIT_A_QUAL] ||
                    mon_i.read == ctrl_ff[dbg_trace_pkg::BIT_A_TYPE]);
  assign match_b = mon_i.valid &&
                   mon_i.addr == {cmp_b_hi_ff, cmp_b_lo_ff} &&
                   (!ctrl_ff[dbg_trace_pkg::BIT_B_QUAL] ||
                    mon_i.read == ctrl_ff[dbg_trace_pkg::BIT_B_TYPE]);
  assign trigger = enable && armed && (match_a || match_b);

  // Event-only runs are always begin traces
  assign begin_mode = begin_trace_i || event_only_i;

  // Capture: event-only stores a data byte on B, otherwise traced flow
  always_comb begin
    if (event_only_i) begin
      store      = enable && armed && match_b;
      store_word = {dbg_trace_pkg::RST_BYTE, mon_i.data};
    end else begin
      store      = enable && armed && mon_i.valid && mon_i.cof &&
                   (!begin_mode || started_ff || trigger);
      store_word = mon_i.addr;
    end
  end

  // Run completion and break request
  assign run_full = store && count_ff == dbg_trace_pkg::FIFO_FULL - 4'h1;
  assign run_done = begin_mode ? run_full : trigger;
  assign brk_fire = ctrl_ff[dbg_trace_pkg::BIT_BRK_EN] && run_done;

  // Comparator registers, locked while armed
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cmp_a_hi_ff <= dbg_trace_pkg::RST_BYTE;
      cmp_a_lo_ff <= dbg_trace_pkg::RST_BYTE;
      cmp_b_hi_ff <= dbg_trace_pkg::RST_BYTE;
      cmp_b_lo_ff <= dbg_trace_pkg::RST_BYTE;
    end else if (cpu_req_i.wr && !armed) begin
      unique case (cpu_req_i.idx)
        dbg_trace_pkg::IDX_CMP_A_HI: cmp_a_hi_ff <= cpu_req_i.wdata;
        dbg_trace_pkg::IDX_CMP_A_LO: cmp_a_lo_ff <= cpu_req_i.wdata;
        dbg_trace_pkg::IDX_CMP_B_HI: cmp_b_hi_ff <= cpu_req_i.wdata;
        dbg_trace_pkg::IDX_CMP_B_LO: cmp_b_lo_ff <= cpu_req_i.wdata;
        default: ;
      endcase
    end
  end

  // Control byte; a software arm in the same cycle as run end wins
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl_ff <= dbg_trace_pkg::RST_BYTE;
    end else if (cpu_wr_ctrl) begin
      ctrl_ff <= cpu_req_i.wdata;
      // Enable only rises when not secured, and stays low if cleared
      ctrl_ff[dbg_trace_pkg::BIT_ENABLE] <=
        cpu_req_i.wdata[dbg_trace_pkg::BIT_ENABLE] &&
        (enable || !secure_i);
      // Arm needs the enable written alongside; zero to either stops
      ctrl_ff[dbg_trace_pkg::BIT_ARM] <=
        cpu_req_i.wdata[dbg_trace_pkg::BIT_ARM] &&
        cpu_req_i.wdata[dbg_trace_pkg::BIT_ENABLE] &&
        (enable || !secure_i);
    end else if (run_done) begin
      ctrl_ff[dbg_trace_pkg::BIT_ARM] <= 1'b0;
    end
  end

  // Run bookkeeping: count and begin-trace start, cleared on arming
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      count_ff   <= dbg_trace_pkg::RST_COUNT;
      started_ff <= 1'b0;
    end else if (cpu_wr_ctrl && cpu_req_i.wdata[dbg_trace_pkg::BIT_ARM]) begin
      count_ff   <= dbg_trace_pkg::RST_COUNT;
      started_ff <= 1'b0;
    end else begin
      if (store && count_ff != dbg_trace_pkg::FIFO_FULL) begin
        count_ff <= count_ff + 4'h1;
      end
      if (trigger) begin
        started_ff <= 1'b1;
      end
    end
  end

  // Most recently fetched opcode address, for profiling
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      op_addr_ff <= dbg_trace_pkg::RST_WORD;
    end else if (mon_i.valid && mon_i.fetch) begin
      op_addr_ff <= mon_i.addr;
    end
  end

  // Trace FIFO as a shift line: entry 0 is read out, entry 7 is loaded.
  // Capture and unarmed reads share the shift, so profiling wraps after
  // eight reads and the ninth returns what the first one loaded.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < dbg_trace_pkg::FIFO_DEPTH; i++) begin
        fifo_ff[i] <= dbg_trace_pkg::RST_WORD;
      end
    end else if (store || (rd_lo && !armed)) begin
      for (int i = 0; i < dbg_trace_pkg::FIFO_DEPTH - 1; i++) begin
        fifo_ff[i] <= fifo_ff[i + 1];
      end
      fifo_ff[dbg_trace_pkg::FIFO_DEPTH - 1] <=
        store ? store_word : op_addr_ff;
    end
  end

  // Read multiplexer; reserved and write-only bytes read as zero
  always_comb begin
    nxt_rdata = dbg_trace_pkg::RST_BYTE;
    unique case (cpu_req_i.idx)
      dbg_trace_pkg::IDX_CMP_A_HI: nxt_rdata = cmp_a_hi_ff;
      dbg_trace_pkg::IDX_CMP_A_LO: nxt_rdata = cmp_a_lo_ff;
      dbg_trace_pkg::IDX_CMP_B_HI: nxt_rdata = cmp_b_hi_ff;
      dbg_trace_pkg::IDX_CMP_B_LO: nxt_rdata = cmp_b_lo_ff;
      dbg_trace_pkg::IDX_FIFO_HI:
        nxt_rdata = event_only_i ? dbg_trace_pkg::RST_BYTE
                                 : fifo_ff[0][15:8];
      dbg_trace_pkg::IDX_FIFO_LO:  nxt_rdata = fifo_ff[0][7:0];
      dbg_trace_pkg::IDX_CTRL:     nxt_rdata = ctrl_ff;
      dbg_trace_pkg::IDX_STATUS: begin
        nxt_rdata[3:0] = count_ff;
        nxt_rdata[dbg_trace_pkg::BIT_ARMED_ST] = armed;
      end
      default: nxt_rdata = dbg_trace_pkg::RST_BYTE;
    endcase
  end

  // Read data is registered one cycle after the read strobe
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_ff <= dbg_trace_pkg::RST_BYTE;
    end else if (cpu_req_i.rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Force reset: only the host port reaches this byte
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sys_reset_ff <= 1'b0;
    end else begin
      sys_reset_ff <= host_wr_i &&
                      host_idx_i == dbg_trace_pkg::IDX_FORCE_RST &&
                      host_wdata_i[dbg_trace_pkg::BIT_FORCE_RST];
    end
  end

  // Break request pulse and its type, type masked when breaks are off
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      break_req_ff <= 1'b0;
      break_tag_ff <= 1'b0;
    end else begin
      break_req_ff <= brk_fire;
      break_tag_ff <= ctrl_ff[dbg_trace_pkg::BIT_BRK_EN] &&
                      ctrl_ff[dbg_trace_pkg::BIT_TAG];
    end
  end

  assign rdata_o     = rdata_ff;
  assign sys_reset_o = sys_reset_ff;
  assign break_req_o = break_req_ff;
  assign break_tag_o = break_tag_ff;
  assign armed_o     = ctrl_ff[dbg_trace_pkg::BIT_ARM];

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_unarmed_low_read;
    rd_lo && !armed && !store;
  endsequence

  sequence s_profile_loaded;
    ##1 fifo_ff[dbg_trace_pkg::FIFO_DEPTH - 1] == $past(op_addr_ff);
  endsequence

  chk_force_cpu_ignored: assert property (
    !host_wr_i ##1 1'b1 |-> !sys_reset_o)
    else $error("force reset without host write");

  chk_force_reads_zero: assert property (
    cpu_req_i.rd && cpu_req_i.idx == dbg_trace_pkg::IDX_FORCE_RST
    |=> rdata_o == 8'h00)
    else $error("force reset byte read nonzero");

  chk_force_reset_pulse: assert property (
    host_wr_i && host_idx_i == dbg_trace_pkg::IDX_FORCE_RST &&
    host_wdata_i[0] |=> sys_reset_o)
    else $error("host force reset not issued");

  chk_cmp_write_lock: assert property (
    armed && cpu_req_i.wr |=> $stable({cmp_a_hi_ff, cmp_a_lo_ff,
                                       cmp_b_hi_ff, cmp_b_lo_ff}))
    else $error("comparator changed while armed");

  chk_fifo_hi_event: assert property (
    cpu_req_i.rd && cpu_req_i.idx == dbg_trace_pkg::IDX_FIFO_HI &&
    event_only_i |=> rdata_o == 8'h00)
    else $error("event-only high byte nonzero");

  chk_fifo_armed_hold: assert property (
    rd_lo && armed && !store |=> $stable(fifo_ff[0]))
    else $error("armed low read advanced fifo");

  chk_profile_load_op: assert property (
    s_unarmed_low_read |-> s_profile_loaded)
    else $error("profile address not loaded");

  chk_enable_secure: assert property (
    secure_i && !enable |=> !enable)
    else $error("module enabled while secure");

  chk_arm_run_end: assert property (
    run_done && !cpu_wr_ctrl |=> !armed_o)
    else $error("armed flag not cleared at run end");

  chk_break_on_end: assert property (
    trigger && !begin_mode && ctrl_ff[4] |=> break_req_o)
    else $error("end trace trigger gave no break");

  // Begin traces break on the filling store, not on the trigger
  chk_break_on_full: assert property (
    run_full && begin_mode && ctrl_ff[dbg_trace_pkg::BIT_BRK_EN]
    |=> break_req_o)
    else $error("begin trace full gave no break");

  chk_break_off_quiet: assert property (
    !ctrl_ff[dbg_trace_pkg::BIT_BRK_EN] |=> !break_req_o)
    else $error("break raised with breaks disabled");

  chk_break_tag_mask: assert property (
    !ctrl_ff[dbg_trace_pkg::BIT_BRK_EN] |=> !break_tag_o)
    else $error("break type shown with breaks disabled");

  // High byte reads are side-effect free; low reads shift when idle
  chk_fifo_hi_hold: assert property (
    cpu_req_i.rd && cpu_req_i.idx == dbg_trace_pkg::IDX_FIFO_HI && !store
    |=> $stable(fifo_ff[0]))
    else $error("high byte read moved fifo");

  chk_fifo_lo_advance: assert property (
    rd_lo && !armed |=> fifo_ff[0] == $past(fifo_ff[1]))
    else $error("unarmed low read did not advance");

  // Event-only entries must never carry anything in the high half
  chk_event_low_only: assert property (
    store && event_only_i
    |=> fifo_ff[dbg_trace_pkg::FIFO_DEPTH - 1][15:8] == 8'h00)
    else $error("event entry high byte nonzero");

  chk_cmp_readback: assert property (
    cpu_req_i.rd && cpu_req_i.idx == dbg_trace_pkg::IDX_CMP_A_HI
    |=> rdata_o == $past(cmp_a_hi_ff))
    else $error("comparator byte read mismatch");

endmodule : debug_trace_and_force_reset

// *** verif/cpu_bus_model.sv ***
// Purpose: CPU bus model that feeds the monitored bus cycle stream
// Assumes: One bus cycle per clock while running, a fetch unless writing, address counts up
// Notes:   Idle bus shows the inverted address, never a stale copy
module cpu_bus_model (
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  // Control from the bench
  input  wire logic                run_i,
  input  wire logic                write_i,
  input  wire logic [15:0]         start_i,
  input  wire logic [7:0]          data_i,
  // Bus cycle stream
  output dbg_trace_pkg::mon_s      mon_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] pc_ff;

  // Counter reloads while the CPU is held, so each run starts at start_i
  always_ff @(posedge clock_i) begin
    if (rst_i || !run_i) begin
      pc_ff <= start_i;
    end else begin
      pc_ff <= pc_ff + 16'h0001;
    end
  end

  // Inverted idle address keeps a released bus from matching by accident
  always_comb begin
    mon_o.valid = run_i;
    mon_o.read  = !write_i;
    mon_o.fetch = run_i && !write_i;
    mon_o.cof   = run_i;
    mon_o.addr  = run_i ? pc_ff : ~pc_ff;
    mon_o.data  = run_i ? data_i : ~data_i;
  end
endmodule : cpu_bus_model

// *** verif/testbench.sv ***
// Purpose: Self-checking bench for the debug trace and force-reset block
// Assumes: Register reads answer one cycle late and then hold
// Notes:   Trigger mode inputs are driven for end, begin and event runs
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic                    clock_i, rst_i, host_wr_i, secure_i, run, wcyc;
  logic                    evt, bgn;
  logic [7:0]              dat;
  logic [3:0]              host_idx_i;
  logic [7:0]              host_wdata_i, rdata_o;
  logic [15:0]             start;
  logic                    sys_reset_o, break_req_o, break_tag_o, armed_o;
  dbg_trace_pkg::reg_req_s cpu_req;
  dbg_trace_pkg::mon_s     mon;
  int                      errors, tests_run, rst_n, brk_n;

  debug_trace_and_force_reset i_debug_trace_and_force_reset (
    .clock_i(clock_i), .rst_i(rst_i), .cpu_req_i(cpu_req),
    .rdata_o(rdata_o), .host_wr_i(host_wr_i), .host_idx_i(host_idx_i),
    .host_wdata_i(host_wdata_i), .secure_i(secure_i),
    .event_only_i(evt), .begin_trace_i(bgn), .mon_i(mon),
    .sys_reset_o(sys_reset_o), .break_req_o(break_req_o),
    .break_tag_o(break_tag_o), .armed_o(armed_o));

  cpu_bus_model i_cpu_bus_model (
    .clock_i(clock_i), .rst_i(rst_i), .run_i(run), .write_i(wcyc),
    .start_i(start), .data_i(dat), .mon_o(mon));

  // Clock at 25 MHz
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // Pulse counters, so one-cycle pulses are never missed between checks
  always @(posedge clock_i) begin
    if (sys_reset_o === 1'b1) rst_n++;
    if (break_req_o === 1'b1) brk_n++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Write ends one edge after the strobe so its effect has landed
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    @(posedge clock_i);
    cpu_req <= '{1'b0, 1'b1, idx, d};
    @(posedge clock_i);
    cpu_req <= '0;
    @(posedge clock_i);
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
    @(posedge clock_i);
    cpu_req <= '{1'b1, 1'b0, idx, 8'h00};
    @(posedge clock_i);
    cpu_req <= '0;
    @(posedge clock_i);
    #1 chk({8'h00, rdata_o}, {8'h00, exp});
  endtask : rd

  task automatic host(input logic [3:0] idx, input logic [7:0] d);
    @(posedge clock_i);
    host_wr_i    <= 1'b1;
    host_idx_i   <= idx;
    host_wdata_i <= d;
    @(posedge clock_i);
    host_wr_i <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask : host

  // Eight bus cycles from a, read or write, then the bus is released
  task automatic cpu_run(input logic [15:0] a, input logic w);
    @(posedge clock_i);
    start <= a;
    wcyc  <= w;
    @(posedge clock_i);
    run <= 1'b1;
    repeat (8) @(posedge clock_i);
    run <= 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
  endtask : cpu_run

  task automatic stop_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // Watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    #(40 * 20000);
    errors++;
    stop_test();
  end

  initial begin
    {rst_i, host_wr_i, secure_i, run, wcyc} = 5'b10000;
    {host_idx_i, host_wdata_i, start} = '0;
    cpu_req = '0;
    {evt, bgn, dat} = '0;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    // Reset values of force-reset and comparator bytes
    for (int i = 0; i < 5; i++) rd(4'(i), 8'h00);
    // Program writes and wrong host targets never force a reset
    wr(dbg_trace_pkg::IDX_FORCE_RST, 8'h01);
    host(4'h3, 8'h01);
    host(dbg_trace_pkg::IDX_FORCE_RST, 8'h00);
    chk(16'(rst_n), 16'h0000);
    host(dbg_trace_pkg::IDX_FORCE_RST, 8'h01);
    chk(16'(rst_n), 16'h0001);
    rd(dbg_trace_pkg::IDX_FORCE_RST, 8'h00);
    // Comparators: A at 1240, B at 1241
    wr(dbg_trace_pkg::IDX_CMP_A_HI, 8'h12);
    wr(dbg_trace_pkg::IDX_CMP_A_LO, 8'h40);
    wr(dbg_trace_pkg::IDX_CMP_B_HI, 8'h12);
    wr(dbg_trace_pkg::IDX_CMP_B_LO, 8'h41);
    rd(dbg_trace_pkg::IDX_CMP_A_LO, 8'h40);
    rd(dbg_trace_pkg::IDX_CMP_B_LO, 8'h41);
    // Secured chip refuses the enable bit
    @(posedge clock_i) secure_i <= 1'b1;
    wr(dbg_trace_pkg::IDX_CTRL, 8'h80);
    rd(dbg_trace_pkg::IDX_CTRL, 8'h00);
    @(posedge clock_i) secure_i <= 1'b0;
    // Profiling: each priming read follows a run on a new page, so every
    // entry differs and a stray shift shows up in the high byte
    for (int i = 0; i < 8; i++) begin
      cpu_run(16'h122D + 16'(i * 256), 1'b0);
      rd(dbg_trace_pkg::IDX_FIFO_LO, 8'h00);
    end
    wr(dbg_trace_pkg::IDX_FIFO_HI, 8'h77);
    rd(dbg_trace_pkg::IDX_FIFO_HI, 8'h12);
    rd(dbg_trace_pkg::IDX_FIFO_HI, 8'h12);
    rd(dbg_trace_pkg::IDX_FIFO_LO, 8'h34);
    rd(dbg_trace_pkg::IDX_FIFO_HI, 8'h13);
    // End trace, force break, then comparator writes locked while armed
    wr(dbg_trace_pkg::IDX_CTRL, 8'hD0);
    chk(16'(armed_o), 16'h0001);
    cpu_run(16'h123C, 1'b0);
    chk({brk_n[7:0], 7'h00, armed_o}, 16'h0100);
    chk(16'(break_tag_o), 16'h0000);
    wr(dbg_trace_pkg::IDX_CTRL, 8'hF0);
    wr(dbg_trace_pkg::IDX_CMP_A_HI, 8'h55);
    rd(dbg_trace_pkg::IDX_CMP_A_HI, 8'h12);
    cpu_run(16'h123C, 1'b0);
    chk({brk_n[7:0], 7'h00, break_tag_o}, 16'h0201);
    // Without break enable the run still ends, silently
    wr(dbg_trace_pkg::IDX_CTRL, 8'hC0);
    cpu_run(16'h123C, 1'b0);
    chk({brk_n[7:0], 7'h00, armed_o}, 16'h0200);
    // Both comparators write-only: read cycles never trigger
    wr(dbg_trace_pkg::IDX_CTRL, 8'hD5);
    cpu_run(16'h123C, 1'b0);
    chk({brk_n[7:0], 7'h00, armed_o}, 16'h0201);
    rd(dbg_trace_pkg::IDX_STATUS, 8'h28);
    // Armed low reads leave the oldest entry in place
    rd(dbg_trace_pkg::IDX_FIFO_LO, 8'h3C);
    rd(dbg_trace_pkg::IDX_FIFO_LO, 8'h3C);
    wr(dbg_trace_pkg::IDX_CTRL, 8'h00);
    chk(16'(armed_o), 16'h0000);
    // Write cycles do match the write-only comparator A
    wr(dbg_trace_pkg::IDX_CTRL, 8'hD5);
    cpu_run(16'h123C, 1'b1);
    chk({brk_n[7:0], 7'h00, armed_o}, 16'h0300);
    // A write-only, B read-only: comparator B fires on reads
    wr(dbg_trace_pkg::IDX_CTRL, 8'hD7);
    cpu_run(16'h123C, 1'b0);
    chk({brk_n[7:0], 7'h00, armed_o}, 16'h0400);
    // Begin trace: storing starts at the trigger, break once full
    @(posedge clock_i) bgn <= 1'b1;
    wr(dbg_trace_pkg::IDX_CTRL, 8'hD0);
    cpu_run(16'h123C, 1'b0);
    chk({brk_n[7:0], 7'h00, armed_o}, 16'h0401);
    cpu_run(16'h123C, 1'b0);
    chk({brk_n[7:0], 7'h00, armed_o}, 16'h0500);
    // Event-only: high byte reads zero, each B match stores a data byte
    @(posedge clock_i) evt <= 1'b1;
    rd(dbg_trace_pkg::IDX_FIFO_HI, 8'h00);
    wr(dbg_trace_pkg::IDX_CTRL, 8'hD0);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock_i) dat <= 8'(8'hA0 + i);
      cpu_run(16'h123C, 1'b0);
    end
    chk({brk_n[7:0], 7'h00, armed_o}, 16'h0600);
    rd(dbg_trace_pkg::IDX_STATUS, 8'h08);
    for (int i = 0; i < 8; i++) begin
      rd(dbg_trace_pkg::IDX_FIFO_LO, 8'(8'hA0 + i));
    end
    stop_test();
  end
endmodule : testbench
